//--- rdk_restore_defaults_key.v
// Restore-defaults key command logic with parameter and backup store
`timescale 1ns/100ps
`include "rdk_defines.vh"
module rdk_restore_defaults_key #(
	parameter        NPARAM     = 4,
	parameter        NBACKUP    = 2,
	parameter        ALT_KEY_EN = 1,
	parameter [31:0] PARAM_DEF  = `RDK_PARAM_RESET,
	parameter [31:0] BACKUP_DEF = `RDK_BACKUP_RESET
) (
	// Clock and reset
	input  wire        clock,
	input  wire        rst,
	// Object dictionary access from the mailbox
	input  wire        od_wr,
	input  wire        od_rd,
	input  wire [15:0] od_index,
	input  wire [7:0]  od_sub,
	input  wire [31:0] od_wdata,
	output reg  [31:0] od_rdata,
	output reg         od_rvalid,
	// Parameter and backup object contents
	output reg  [NPARAM*32-1:0]  param_q,
	output reg  [NBACKUP*32-1:0] backup_q
);
	// Key comparison results
	wire                  main_hit;
	wire                  alt_hit;
	wire                  alt_key_on;

	// Request decode
	wire                  key_sel;
	wire                  key_wr;
	wire                  restore_go;
	wire [NPARAM-1:0]     param_sel;
	wire [NBACKUP-1:0]    backup_sel;
	wire [NPARAM-1:0]     param_we;
	wire [NBACKUP-1:0]    backup_we;

	// Next values of the stores
	reg  [NPARAM*32-1:0]  param_nxt;
	reg  [NBACKUP*32-1:0] backup_nxt;

	// Read path staging
	reg  [31:0]           param_word;
	reg                   param_found;
	reg  [31:0]           backup_word;
	reg                   backup_found;
	reg  [31:0]           rdata_nxt;
	reg                   rvalid_nxt;

	// Loop indices, one per process
	integer               k;
	integer               m;
	integer               n;
	integer               p;

	// Reset images of the stores
	localparam [NPARAM*32-1:0]  PARAM_INIT  = {NPARAM{PARAM_DEF}};
	localparam [NBACKUP*32-1:0] BACKUP_INIT = {NBACKUP{BACKUP_DEF}};

	// Restore entry address check
	function entry_hit;
		input [15:0] idx;
		input [7:0]  sub;
		begin
			entry_hit = (idx == `RDK_ENTRY_INDEX) && (sub == `RDK_ENTRY_SUB);
		end
	endfunction

	// Store slot address check: base index plus slot number, fixed subindex
	function slot_hit;
		input [15:0]  idx;
		input [7:0]   sub;
		input [15:0]  base;
		input integer slot;
		reg   [15:0]  target;
		begin
			target   = base + slot[15:0];
			slot_hit = (idx == target) && (sub == `RDK_STORE_SUB);
		end
	endfunction

	// Next word of one store slot; a restore beats a same-cycle write
	function [31:0] next_word;
		input [31:0] cur;
		input        restore;
		input [31:0] def;
		input        we;
		input [31:0] data;
		begin
			if (restore) begin
				next_word = def;
			end else if (we) begin
				next_word = data;
			end else begin
				next_word = cur;
			end
		end
	endfunction

	// Alternative key only on variants that keep it
	assign alt_key_on = (ALT_KEY_EN != 0);

	rdk_key_match i_rdk_key_match (
		.key        (od_wdata),
		.alt_key_en (alt_key_on),
		.main_hit   (main_hit),
		.alt_hit    (alt_hit)
	);

	// A key acts only when written to the restore entry; other values do nothing
	assign key_sel    = entry_hit(od_index, od_sub);
	assign key_wr     = od_wr && key_sel;
	assign restore_go = key_wr && (main_hit || alt_hit);

	// Slot decode for parameters and backups
	genvar g;
	generate
		for (g = 0; g < NPARAM; g = g + 1) begin : gp
			assign param_sel[g] = slot_hit(od_index, od_sub, `RDK_PARAM_BASE, g);
			assign param_we[g]  = od_wr && param_sel[g];
		end
		for (g = 0; g < NBACKUP; g = g + 1) begin : gb
			assign backup_sel[g] = slot_hit(od_index, od_sub, `RDK_BACKUP_BASE, g);
			assign backup_we[g]  = od_wr && backup_sel[g];
		end
	endgenerate

	// Parameter store
	always @* begin
		param_nxt = param_q;
		for (k = 0; k < NPARAM; k = k + 1) begin
			param_nxt[k*32 +: 32] = next_word(param_q[k*32 +: 32], restore_go, PARAM_DEF,
				param_we[k], od_wdata);
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			param_q <= PARAM_INIT;
		end else begin
			param_q <= param_nxt;
		end
	end

	// Backup store, cleared by either accepted key
	always @* begin
		backup_nxt = backup_q;
		for (m = 0; m < NBACKUP; m = m + 1) begin
			backup_nxt[m*32 +: 32] = next_word(backup_q[m*32 +: 32], restore_go, BACKUP_DEF,
				backup_we[m], od_wdata);
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			backup_q <= BACKUP_INIT;
		end else begin
			backup_q <= backup_nxt;
		end
	end

	// Parameter slot selected by the read
	always @* begin
		param_word  = `RDK_RDATA_IDLE;
		param_found = 1'b0;
		for (n = 0; n < NPARAM; n = n + 1) begin
			if (param_sel[n]) begin
				param_word  = param_q[n*32 +: 32];
				param_found = 1'b1;
			end
		end
	end

	// Backup slot selected by the read
	always @* begin
		backup_word  = `RDK_RDATA_IDLE;
		backup_found = 1'b0;
		for (p = 0; p < NBACKUP; p = p + 1) begin
			if (backup_sel[p]) begin
				backup_word  = backup_q[p*32 +: 32];
				backup_found = 1'b1;
			end
		end
	end

	// Read answer: the restore entry never returns the key or a restore status
	always @* begin
		rvalid_nxt = od_rd;
		rdata_nxt  = `RDK_RDATA_IDLE;
		if (od_rd) begin
			if (key_sel) begin
				rdata_nxt = `RDK_READ_VALUE;
			end else if (param_found) begin
				rdata_nxt = param_word;
			end else if (backup_found) begin
				rdata_nxt = backup_word;
			end
		end
	end

	// Read port registers
	always @(posedge clock) begin
		if (rst) begin
			od_rdata  <= `RDK_RDATA_IDLE;
			od_rvalid <= 1'b0;
		end else begin
			od_rdata  <= rdata_nxt;
			od_rvalid <= rvalid_nxt;
		end
	end
endmodule

//--- rdk_defines.vh
// Constants for the restore-defaults key command block
`ifndef RDK_DEFINES_VH
`define RDK_DEFINES_VH
`define RDK_ENTRY_INDEX    16'h1011
`define RDK_ENTRY_SUB      8'h01
`define RDK_PARAM_BASE     16'h2000
`define RDK_BACKUP_BASE    16'h10F0
`define RDK_STORE_SUB      8'h01
`define RDK_KEY_MAIN       32'h6461_6F6C
`define RDK_KEY_ALT        32'h6C6F_6164
`define RDK_READ_VALUE     32'h0000_0000
`define RDK_PARAM_RESET    32'h0000_0000
`define RDK_BACKUP_RESET   32'h0000_0000
`define RDK_RDATA_IDLE     32'h0000_0000
`endif

//--- rdk_key_match.v
// Key comparator for the restore entry
`timescale 1ns/100ps
module rdk_key_match (
	// Key input
	input  wire [31:0] key,
	input  wire        alt_key_en,
	// Match outputs
	output wire        main_hit,
	output wire        alt_hit
);
	assign main_hit = (key == `RDK_KEY_MAIN);
	assign alt_hit  = alt_key_en && (key == `RDK_KEY_ALT);
endmodule

//--- rdk_props.sv
// Checker for the restore key block
`timescale 1ns/100ps
`include "rdk_defines.vh"
module rdk_props #(parameter NPARAM = 4, parameter NBACKUP = 2, parameter ALT_KEY_EN = 1,
	parameter [31:0] PARAM_DEF = `RDK_PARAM_RESET, parameter [31:0] BACKUP_DEF = `RDK_BACKUP_RESET) (
	input wire clock, rst, od_wr, od_rd, od_rvalid,
	input wire [15:0] od_index,
	input wire [7:0] od_sub,
	input wire [31:0] od_wdata, od_rdata,
	input wire [NPARAM*32-1:0] param_q,
	input wire [NBACKUP*32-1:0] backup_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire ent = od_index == `RDK_ENTRY_INDEX && od_sub == `RDK_ENTRY_SUB;
	wire km = od_wr && ent && od_wdata == `RDK_KEY_MAIN;
	wire ka = od_wr && ent && od_wdata == `RDK_KEY_ALT && ALT_KEY_EN != 0;
	localparam [NPARAM*32-1:0] P_INIT = {NPARAM{PARAM_DEF}};
	localparam [NBACKUP*32-1:0] B_INIT = {NBACKUP{BACKUP_DEF}};
	main_key_a: assert property (km |=> param_q == P_INIT) else $error("param not restored");
	backup_main_a: assert property (km |=> backup_q == B_INIT)
		else $error("backup not restored");
	alt_key_a: assert property (ka |=> param_q == P_INIT && backup_q == B_INIT)
		else $error("alt failed");
	wrong_key_a: assert property (od_wr && ent && !km && !ka |=> $stable(param_q)
		&& $stable(backup_q)) else $error("wrong key changed store");
	zero_read_a: assert property (od_rd && ent |=> od_rvalid && od_rdata == `RDK_READ_VALUE)
		else $error("entry not 0");
	no_status_a: assert property (!od_rd |=> !od_rvalid) else $error("unrequested status");
	cover property (km);
	cover property (ka);
	cover property (od_rd && ent);
	cover property (od_wr && ent && !km && !ka);
endmodule
bind rdk_restore_defaults_key rdk_props #(.NPARAM(NPARAM), .NBACKUP(NBACKUP), .ALT_KEY_EN(ALT_KEY_EN),
	.PARAM_DEF(PARAM_DEF), .BACKUP_DEF(BACKUP_DEF))
	i_rdk_props (.clock(clock), .rst(rst), .od_wr(od_wr), .od_rd(od_rd), .od_rvalid(od_rvalid),
	.od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata(od_rdata),
	.param_q(param_q), .backup_q(backup_q));

//--- rdk_master.sv
// Fieldbus master model writing and reading dictionary entries
`timescale 1ns/100ps
module rdk_master (input wire clock, output reg od_wr, od_rd, output reg [15:0] od_index,
	output reg [7:0] od_sub, output reg [31:0] od_wdata);
	initial {od_wr, od_rd, od_index, od_sub, od_wdata} = 0;
	// Only dictionary entries are written here, never firmware
	task wr(input [15:0] i, input [31:0] d); begin
		@(posedge clock); od_wr <= 1; od_index <= i; od_sub <= 8'h01; od_wdata <= d;
		@(posedge clock); od_wr <= 0; od_wdata <= ~d;
	end endtask
	task rd(input [15:0] i); begin
		@(posedge clock); od_rd <= 1; od_index <= i; od_sub <= 8'h01;
		@(posedge clock); od_rd <= 0;
	end endtask
endmodule

//--- rdk_restore_defaults_key_bench.sv
// Testbench for the restore key block
`timescale 1ns/100ps
`include "rdk_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module rdk_restore_defaults_key_bench;
	reg clock = 0, rst = 1;
	wire od_wr, od_rd, od_rvalid;
	wire [15:0] od_index;
	wire [7:0] od_sub;
	wire [31:0] od_wdata, od_rdata;
	wire [127:0] param_q;
	wire [63:0] backup_q;
	int fail_count = 0, comparisons = 0;
	always #12.5 clock = ~clock;
	rdk_master i_rdk_master (.clock(clock), .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index),
		.od_sub(od_sub), .od_wdata(od_wdata));
	rdk_restore_defaults_key i_rdk_restore_defaults_key (.clock(clock), .rst(rst), .od_wr(od_wr),
		.od_rd(od_rd), .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata),
		.od_rdata(od_rdata), .od_rvalid(od_rvalid), .param_q(param_q), .backup_q(backup_q));
	task give_verdict; begin
		if (fail_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	end endtask
	task t_startup; begin
		i_rdk_master.wr(16'h1011, `RDK_KEY_MAIN);
		@(negedge clock);
		`CHK(param_q, {4{`RDK_PARAM_RESET}})
		`CHK(backup_q, {2{`RDK_BACKUP_RESET}})
	end endtask
	task t_wrong; begin
		i_rdk_master.wr(16'h2000, 32'h0000_0005);
		i_rdk_master.wr(16'h1011, 32'h6461_6F6D);
		i_rdk_master.rd(16'h1011);
		@(negedge clock);
		`CHK(param_q[31:0], 32'h0000_0005)
		`CHK(od_rvalid, 1'b1)
		`CHK(od_rdata, `RDK_READ_VALUE)
		i_rdk_master.rd(16'h2000);
		@(negedge clock);
		`CHK(od_rdata, 32'h0000_0005)
	end endtask
	task t_main; begin
		i_rdk_master.wr(16'h10F0, 32'h0000_0007);
		i_rdk_master.wr(16'h2001, 32'h0000_0009);
		@(negedge clock);
		`CHK(backup_q[31:0], 32'h0000_0007)
		`CHK(param_q[63:32], 32'h0000_0009)
		i_rdk_master.wr(16'h1011, `RDK_KEY_MAIN);
		@(negedge clock);
		`CHK(param_q, {4{`RDK_PARAM_RESET}})
		`CHK(backup_q, {2{`RDK_BACKUP_RESET}})
		`CHK(od_rvalid, 1'b0)
		i_rdk_master.rd(16'h2001);
		@(negedge clock);
		`CHK(od_rdata, `RDK_PARAM_RESET)
		i_rdk_master.rd(16'h1011);
		@(negedge clock);
		`CHK(od_rdata, `RDK_READ_VALUE)
	end endtask
	task t_alt; begin
		i_rdk_master.wr(16'h10F1, 32'h0000_0003);
		i_rdk_master.wr(16'h2003, 32'h0000_000C);
		@(negedge clock);
		`CHK(backup_q[63:32], 32'h0000_0003)
		i_rdk_master.wr(16'h1011, `RDK_KEY_ALT);
		@(negedge clock);
		`CHK(backup_q, {2{`RDK_BACKUP_RESET}})
		`CHK(param_q, {4{`RDK_PARAM_RESET}})
	end endtask
	task t_reset; begin
		i_rdk_master.wr(16'h2002, 32'h0000_0011);
		@(negedge clock);
		`CHK(param_q[95:64], 32'h0000_0011)
		@(posedge clock);
		rst <= 1;
		repeat (2) @(posedge clock);
		rst <= 0;
		@(negedge clock);
		`CHK(param_q, {4{`RDK_PARAM_RESET}})
		`CHK(od_rvalid, 1'b0)
	end endtask
	initial begin
		repeat (10) @(posedge clock);
		rst <= 0;
		t_startup;
		t_wrong;
		t_main;
		t_alt;
		t_reset;
		give_verdict;
	end
	initial begin
		#20000;
		fail_count++;
		give_verdict;
	end
endmodule
